// file: design/vpf_formatter.sv
// Page formatter: peripheral device page and vital product data pages
//
// The implementer's own choices: the APB slave port and the address map.

// What this block does
// - Peripheral page code 09h, savable bit, length n-1
// - Interface id MSB first, bytes 4-7 reserved
// - Interface id code map as defined
// - Vital product data page code map
// - Pages sent only on page-selecting request
// - ASCII opdef header, code 82h, length n-3
// - Page length never reduced by truncation
// - Description length full; zero means no text
// - Text lines graphic bytes, end with 00h; other bytes are still sent, and flagged only on vital product data pages
// - ASCII info page code echoes request
// - Unit codes above 7Fh other than 82h get no page
// - ASCII length full; zero means none
module vpf_formatter
    import vpf_pkg::*;
#(
    parameter int TEXT_DEPTH = 64,
    parameter int TEXT_AW    = 6
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    // Decoded request
    input  wire logic        req_valid,
    input  wire logic        req_vpd,
    input  wire logic [7:0]  req_page,
    input  wire logic [15:0] req_alloc,
    output logic             req_ready,
    output logic             req_reject,
    // Page byte stream
    output logic      [7:0]  out_data,
    output logic             out_valid,
    output logic             out_last,
    input  wire logic        out_ready
);
    initial begin
        if (TEXT_DEPTH > (1 << TEXT_AW) || TEXT_DEPTH > 250) begin
            $error("vpf_formatter: text depth out of range");
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        vpf_state_e  state;
        logic        savable;
        logic [15:0] ifid;
        logic [7:0]  qual;
        logic [7:0]  text_len;
        logic [7:0]  page;
        logic        is_vpd;
        logic [15:0] idx;
        logic [15:0] alloc;
        logic [15:0] total;
        logic [7:0]  data;
        logic        valid;
        logic        last;
        logic        reject;
        logic [31:0] rdata;
        logic [15:0] sent_cnt;
        logic        bad_text;
    } vpf_s;

    vpf_s st_ff;
    vpf_s nxt_st;

    logic       apb_wr;
    logic       text_we;
    logic [7:0] text_rd;
    logic [7:0] body_len;
    logic [TEXT_AW-1:0] text_idx;

    assign apb_wr  = psel && penable && pwrite;
    assign text_we = apb_wr && paddr == REG_TEXT;

    // body text follows the header of the page being sent
    assign text_idx = st_ff.idx[TEXT_AW-1:0]
                    - (st_ff.is_vpd ? TEXT_AW'(VPD_HDR_LEN) : TEXT_AW'(PER_HDR_LEN));

    vpf_text_ram #(
        .DEPTH (TEXT_DEPTH),
        .AW    (TEXT_AW)
    ) u_text (
        .clk     (clk),
        .arst_n  (arst_n),
        .wr_en   (text_we),
        .wr_addr (pwdata[TEXT_AW+7:8]),
        .wr_data (pwdata[7:0]),
        .rd_addr (text_idx),
        .rd_data (text_rd)
    );

    // Page is served only for codes this block builds
    function automatic logic page_known(input logic vpd, input logic [7:0] pc);
        if (!vpd) begin
            return pc == PC_PERIPH;
        end
        // upper unit codes other than 82h have no page
        return pc == PC_ASCII_OPD || (pc >= PC_ASCII_LO && pc <= PC_ASCII_HI);
    endfunction

    // Graphic byte or line end
    function automatic logic text_ok(input logic [7:0] b);
        return (b >= ASCII_MIN && b <= ASCII_MAX) || b == LINE_END;
    endfunction

    // Stored text length clipped to the store
    assign body_len = (int'(st_ff.text_len) > TEXT_DEPTH) ? 8'(TEXT_DEPTH) : st_ff.text_len;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.reject = 1'b0;
        // Register writes: control steers header content
        if (apb_wr && paddr == REG_CTRL) begin
            nxt_st.savable = pwdata[CTRL_SAVABLE];
            // any 16-bit identifier accepted, vendor range included
            nxt_st.ifid    = pwdata[CTRL_IFID_LSB +: 16];
        end
        if (apb_wr && paddr == REG_HDR) begin
            nxt_st.qual = pwdata[HDR_QUAL_LSB +: 8];
        end
        if (apb_wr && paddr == REG_TEXT_LEN) begin
            nxt_st.text_len = pwdata[7:0];
        end
        // Read data captured in setup so it stands in access phase
        case (paddr)
            REG_CTRL:     nxt_st.rdata = {st_ff.ifid, 15'h0000, st_ff.savable};
            REG_HDR:      nxt_st.rdata = {24'h000000, st_ff.qual};
            REG_STATUS:   nxt_st.rdata = {st_ff.sent_cnt, 13'h0000, st_ff.bad_text,
                                          st_ff.state == VPF_SEND, st_ff.is_vpd};
            REG_TEXT_LEN: nxt_st.rdata = {24'h000000, st_ff.text_len};
            default:      nxt_st.rdata = RD_ZERO;
        endcase

        case (st_ff.state)
            VPF_IDLE: begin
                nxt_st.valid = 1'b0;
                nxt_st.last  = 1'b0;
                if (req_valid) begin
                    if (!page_known(req_vpd, req_page) || req_alloc == 16'h0000) begin
                        nxt_st.reject = 1'b1;
                    end else begin
                        nxt_st.page     = req_page;
                        nxt_st.is_vpd   = req_vpd;
                        nxt_st.alloc    = req_alloc;
                        nxt_st.idx      = 16'h0000;
                        nxt_st.sent_cnt = 16'h0000;
                        nxt_st.bad_text = 1'b0;
                        nxt_st.total    = req_vpd ? 16'(VPD_HDR_LEN) + 16'(body_len)
                                                  : 16'(PER_HDR_LEN) + 16'(body_len);
                        nxt_st.state    = VPF_SEND;
                    end
                end
            end
            VPF_SEND: begin
                if (!st_ff.valid || out_ready) begin
                    // Header and body bytes, by position
                    if (!st_ff.is_vpd) begin
                        case (st_ff.idx)
                            16'd0:   nxt_st.data = {st_ff.savable, 1'b0, PC_PERIPH_LO6};
                            // length of bytes after byte 1; never cut
                            16'd1:   nxt_st.data = 8'(st_ff.total - 16'd2);
                            16'd2:   nxt_st.data = st_ff.ifid[15:8];
                            16'd3:   nxt_st.data = st_ff.ifid[7:0];
                            16'd4, 16'd5, 16'd6, 16'd7: nxt_st.data = BYTE_ZERO;
                            default: nxt_st.data = text_rd;
                        endcase
                        if (st_ff.idx == 16'd0) begin
                            nxt_st.data = {st_ff.savable, 1'b0, PC_PERIPH_LO6};
                        end
                    end else begin
                        case (st_ff.idx)
                            16'd0:   nxt_st.data = st_ff.qual;
                            // code 82h; info code echoes request
                            16'd1:   nxt_st.data = st_ff.page;
                            16'd2:   nxt_st.data = BYTE_ZERO;
                            // length after byte 3; never cut
                            16'd3:   nxt_st.data = 8'(st_ff.total - 16'd4);
                            // full text length; zero means none
                            16'd4:   nxt_st.data = body_len;
                            default: nxt_st.data = text_rd;
                        endcase
                        // flag any text byte that is neither graphic nor 00h
                        if (st_ff.idx >= 16'(VPD_HDR_LEN) && !text_ok(text_rd)) begin
                            nxt_st.bad_text = 1'b1;
                        end
                    end
                    nxt_st.valid = 1'b1;
                    nxt_st.idx   = st_ff.idx + 16'd1;
                    // stop at allocation length or page end
                    nxt_st.last  = (st_ff.idx + 16'd1 == st_ff.alloc)
                                || (st_ff.idx + 16'd1 == st_ff.total);
                    if (st_ff.valid) begin
                        nxt_st.sent_cnt = st_ff.sent_cnt + 16'd1;
                    end
                    if (nxt_st.last) begin
                        nxt_st.state = VPF_DONE;
                    end
                end
            end
            VPF_DONE: begin
                if (out_ready) begin
                    nxt_st.valid    = 1'b0;
                    nxt_st.last     = 1'b0;
                    nxt_st.sent_cnt = st_ff.sent_cnt + 16'd1;
                    nxt_st.state    = VPF_IDLE;
                end
            end
            default: nxt_st.state = VPF_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pready     = 1'b1;              // Zero wait states keep the bus simple
    assign pslverr    = 1'b0;
    assign prdata     = st_ff.rdata;
    assign req_ready  = st_ff.state == VPF_IDLE;
    assign req_reject = st_ff.reject;
    assign out_data   = st_ff.data;
    assign out_valid  = st_ff.valid;
    assign out_last   = st_ff.last;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_periph_code: assert property (@(posedge clk) disable iff (!arst_n)
        st_ff.state == VPF_SEND && !st_ff.is_vpd && st_ff.idx == 16'd0 && !st_ff.valid
        |=> out_data[5:0] == PC_PERIPH_LO6 && out_data[7] == st_ff.savable)
        else $error("peripheral page code byte wrong");

    chk_ifid_order: assert property (@(posedge clk) disable iff (!arst_n)
        out_valid && out_ready && !st_ff.is_vpd && st_ff.idx == 16'd3 && !out_last
        |=> out_data == st_ff.ifid[7:0])
        else $error("identifier low byte out of order");

    chk_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
        out_valid && !st_ff.is_vpd && st_ff.idx >= 16'd5 && st_ff.idx <= 16'd8
        |-> out_data == BYTE_ZERO)
        else $error("reserved byte not zero");

    chk_no_unknown: assert property (@(posedge clk) disable iff (!arst_n)
        req_valid && req_ready && req_vpd && req_page > PC_ASCII_HI
        && req_page != PC_ASCII_OPD |=> req_reject && !out_valid)
        else $error("page served for unknown code");

    chk_page_echo: assert property (@(posedge clk) disable iff (!arst_n)
        out_valid && st_ff.is_vpd && st_ff.idx == 16'd2 |-> out_data == st_ff.page)
        else $error("page code not echoed");

    chk_len_full: assert property (@(posedge clk) disable iff (!arst_n)
        out_valid && st_ff.is_vpd && st_ff.idx == 16'd4
        |-> out_data == body_len + 8'(VPD_HDR_LEN - 4))
        else $error("page length cut");

    chk_desc_len: assert property (@(posedge clk) disable iff (!arst_n)
        out_valid && st_ff.is_vpd && st_ff.idx == 16'd5 |-> out_data == body_len)
        else $error("text length byte wrong");

    chk_periph_len: assert property (@(posedge clk) disable iff (!arst_n)
        out_valid && !st_ff.is_vpd && st_ff.idx == 16'd2
        |-> out_data == body_len + 8'(PER_HDR_LEN - 2))
        else $error("peripheral page length wrong");

    chk_alloc_stop: assert property (@(posedge clk) disable iff (!arst_n)
        out_valid && out_last |-> st_ff.idx == st_ff.alloc || st_ff.idx == st_ff.total)
        else $error("stream ended at wrong byte");

    chk_idle_quiet: assert property (@(posedge clk) disable iff (!arst_n)
        st_ff.state == VPF_IDLE && !req_valid |=> !out_valid)
        else $error("bytes sent with no request");

    chk_hold_data: assert property (@(posedge clk) disable iff (!arst_n)
        out_valid && !out_ready |=> $stable(out_data) && out_valid)
        else $error("byte dropped under stall");
endmodule // vpf_formatter

// file: design/vpf_pkg.sv
// Package for the page formatter: page codes, header layouts, bus map
package vpf_pkg;
    // ------------------------------------------------------------
    // Page codes
    // ------------------------------------------------------------
    localparam logic [7:0] PC_SUPPORTED  = 8'h00;
    localparam logic [7:0] PC_ASCII_LO   = 8'h01;
    localparam logic [7:0] PC_ASCII_HI   = 8'h7F;
    localparam logic [7:0] PC_SERIAL     = 8'h80;
    localparam logic [7:0] PC_OPDEF      = 8'h81;
    localparam logic [7:0] PC_ASCII_OPD  = 8'h82;
    localparam logic [7:0] PC_RSV_LO     = 8'h83;
    localparam logic [7:0] PC_RSV_HI     = 8'hBF;
    localparam logic [7:0] PC_PERIPH     = 8'h09;
    localparam logic [5:0] PC_PERIPH_LO6 = 6'h09;
    // ------------------------------------------------------------
    // Interface identifier codes
    // ------------------------------------------------------------
    localparam logic [15:0] IFID_PARALLEL = 16'h0000;
    localparam logic [15:0] IFID_LAST_STD = 16'h0004;
    localparam logic [15:0] IFID_VENDOR   = 16'h8000;
    // ------------------------------------------------------------
    // Byte positions and fixed values
    // ------------------------------------------------------------
    localparam int          PER_HDR_LEN   = 8;   // Vendor data starts here
    localparam int          VPD_HDR_LEN   = 5;   // Text starts here
    localparam logic [7:0]  ASCII_MIN     = 8'h20;
    localparam logic [7:0]  ASCII_MAX     = 8'h7E;
    localparam logic [7:0]  LINE_END      = 8'h00;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_HDR       = 8'h04;
    localparam logic [7:0]  REG_STATUS    = 8'h08;
    localparam logic [7:0]  REG_TEXT      = 8'h0C;
    localparam logic [7:0]  REG_TEXT_LEN  = 8'h10;
    localparam logic [31:0] RD_ZERO       = 32'h0000_0000;
    localparam int          CTRL_SAVABLE  = 0;
    localparam int          CTRL_IFID_LSB = 16;
    localparam int          HDR_QUAL_LSB  = 0;
    // Formatter states
    typedef enum logic [1:0] {VPF_IDLE, VPF_SEND, VPF_DONE} vpf_state_e;
endpackage : vpf_pkg

// file: design/vpf_text_ram.sv
// Text store for page bodies, written over the bus, read by the formatter
module vpf_text_ram
    import vpf_pkg::*;
#(
    parameter int DEPTH = 64,
    parameter int AW    = 6
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          arst_n,
    // Write side
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    // Read side
    input  wire logic [AW-1:0] rd_addr,
    output logic      [7:0]    rd_data
);
    initial begin
        if (DEPTH > (1 << AW) || DEPTH < 2) begin
            $error("vpf_text_ram: depth does not fit address width");
        end
    end

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
    } vpf_ram_s;

    vpf_ram_s st_ff;
    vpf_ram_s nxt_st;

    // Byte write into the addressed entry
    always_comb begin
        nxt_st = st_ff;
        if (wr_en && int'(wr_addr) < DEPTH) begin
            nxt_st.mem[wr_addr] = wr_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Out of range reads as zero, the line terminator
    assign rd_data = (int'(rd_addr) < DEPTH) ? st_ff.mem[rd_addr] : LINE_END;
endmodule // vpf_text_ram

// file: verif/vpf_formatter_test.sv
// Self-checking bench for the page formatter
module vpf_formatter_test
    import vpf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, req_valid, req_vpd, req_ready, req_reject;
    logic [7:0]  req_page, out_data, hdr, rp;
    logic [15:0] req_alloc, ifid;
    logic        out_valid, out_last, out_ready, sav, rv;
    logic [7:0]  txt[64];
    int          tlen, n_fail, compares;
    logic [15:0] ids[9] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005,
                            16'h7FFF, 16'h8000, 16'hFFFF};
    logic [15:0] allocs[7] = '{16'd1, 16'd3, 16'd4, 16'd5, 16'd34, 16'd35, 16'd300};
    logic [7:0]  rej_pg[7] = '{8'h00, 8'h80, 8'h81, 8'h83, 8'hBF, 8'hC0, 8'hFF};
    logic [7:0]  regs[5] = '{REG_CTRL, REG_HDR, REG_STATUS, REG_TEXT, 8'h14};

    always #5 clk = ~clk;

    vpf_formatter #(.TEXT_DEPTH(64), .TEXT_AW(6)) i_dut (
        .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .req_valid, .req_vpd, .req_page, .req_alloc, .req_ready, .req_reject,
        .out_data, .out_valid, .out_last, .out_ready);

    vpf_host_model i_host (
        .clk, .arst_n, .req_valid, .req_vpd, .req_page, .req_alloc, .req_ready, .req_reject,
        .out_data, .out_valid, .out_last, .out_ready);

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One APB transfer; read data lands in rd at the completing edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!pready && n < 20);
        if (!pready) begin
            n_fail++;
            end_of_test();
        end
        rd = prdata;
        check(pslverr, 1'b0, "bus error");
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Text in lines of graphic bytes, each closed by 00h; bad puts a control byte first
    task automatic load_text(input int len, input bit bad);
        for (int i = 0; i < len; i++) begin
            txt[i] = ($urandom_range(5) == 0 || i == len - 1) ? 8'h00
                     : 8'(8'h20 + $urandom_range(94));
            if (bad && i == 0) txt[i] = 8'h07;
            apb(1'b1, REG_TEXT, {18'h0, 6'(i), txt[i]});
        end
        tlen = len;
        apb(1'b1, REG_TEXT_LEN, 32'(len));
    endtask

    // Full page image; lengths count the whole page, never the allocation
    function automatic int build(input logic vpd, input logic [7:0] page,
                                 output logic [7:0] img[72]);
        int h;
        h = vpd ? VPD_HDR_LEN : PER_HDR_LEN;
        foreach (img[i]) img[i] = 8'h00;
        if (vpd) begin
            img[0] = hdr;
            img[1] = page;
            img[3] = 8'(h + tlen - 4);
            img[4] = 8'(tlen);
        end else begin
            img[0] = {sav, 1'b0, 6'h09};
            img[1] = 8'(h + tlen - 2);
            img[2] = ifid[15:8];
            img[3] = ifid[7:0];
        end
        for (int i = 0; i < tlen; i++) img[h + i] = txt[i];
        return h + tlen;
    endfunction

    task automatic run(input logic vpd, input logic [7:0] page, input logic [15:0] alloc,
                       input bit stall);
        logic [7:0] img[72];
        int         total;
        int         cnt;
        bit         bad;
        total = build(vpd, page, img);
        bad = alloc == 0 || (vpd ? !(page inside {[8'h01:8'h7F], 8'h82}) : page != 8'h09);
        cnt = (alloc < total) ? int'(alloc) : total;
        i_host.fetch(vpd, page, alloc, stall);
        if (i_host.hung) begin
            n_fail++;
            end_of_test();
        end
        check(i_host.rej, bad, "refusal");
        if (!bad) begin
            check(i_host.got.size(), cnt, "byte count");
            foreach (i_host.got[i]) check(i_host.got[i], img[i], "page byte");
            apb(1'b0, REG_STATUS, 32'h0);
            check(rd[31:16], cnt, "accepted count");
            check(rd[0], vpd, "page kind");
        end
        $display("test done: vpd %0d page %h alloc %0d", vpd, page, alloc);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(69198));
        n_fail = 0;
        compares = 0;
        repeat (5) @(posedge clk);
        check(req_ready, 1'b1, "ready in reset");
        check(out_valid, 1'b0, "valid in reset");
        arst_n <= 1'b1;
        apb(1'b1, 8'h14, 32'hFFFF_FFFF);
        foreach (regs[k]) begin
            apb(1'b0, regs[k], 32'h0);
            check(rd, 32'h0, "reset value");
        end
        $display("test done: reset and access kinds");
        // Peripheral page across every interface id class
        foreach (ids[k]) begin
            sav  = 1'($urandom_range(1));
            ifid = ids[k];
            apb(1'b1, REG_CTRL, {ifid, 15'h0, sav});
            apb(1'b0, REG_CTRL, 32'h0);
            check(rd, {ifid, 15'h0, sav}, "control");
            load_text($urandom_range(1, 20), 1'b0);
            run(1'b0, 8'h09, 16'd200, k[0]);
        end
        // Operating definition text page cut at every boundary
        hdr = 8'($urandom);
        apb(1'b1, REG_HDR, 32'(hdr));
        load_text(30, 1'b0);
        foreach (allocs[k]) run(1'b1, 8'h82, allocs[k], 1'b1);
        // Information pages at the code limits and with no text
        run(1'b1, 8'h01, 16'd64, 1'b0);
        run(1'b1, 8'h7F, 16'd64, 1'b1);
        load_text(0, 1'b0);
        run(1'b1, 8'h40, 16'd10, 1'b0);
        // Refused codes and zero allocation
        foreach (rej_pg[k]) run(1'b1, rej_pg[k], 16'd50, 1'b0);
        run(1'b0, 8'h0A, 16'd50, 1'b0);
        run(1'b1, 8'h01, 16'd0, 1'b0);
        run(1'b0, 8'h09, 16'd0, 1'b0);
        // Non-graphic text is flagged, clean text clears it
        load_text(8, 1'b1);
        run(1'b1, 8'h05, 16'd20, 1'b0);
        check(rd[2], 1'b1, "text flag set");
        load_text(8, 1'b0);
        run(1'b1, 8'h05, 16'd20, 1'b0);
        check(rd[2], 1'b0, "text flag clear");
        // Random requests, each after a fresh text load
        repeat (8) begin
            rv = 1'($urandom_range(1));
            rp = rv ? 8'($urandom_range(1, 127)) : 8'h09;
            load_text($urandom_range(0, 40), 1'b0);
            run(rv, rp, 16'($urandom_range(1, 60)), 1'b1);
        end
        end_of_test();
    end
endmodule // vpf_formatter_test

// file: verif/vpf_host_model.sv
// Initiator-side model: issues page requests and sinks the page bytes
module vpf_host_model
    import vpf_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Request side
    output logic             req_valid,
    output logic             req_vpd,
    output logic [7:0]       req_page,
    output logic [15:0]      req_alloc,
    input  wire logic        req_ready,
    input  wire logic        req_reject,
    // Byte sink
    input  wire logic [7:0]  out_data,
    input  wire logic        out_valid,
    input  wire logic        out_last,
    output logic             out_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] got[$];
    bit         rej;
    bit         hung;

    // Idle values at time zero
    initial begin
        req_valid = 1'b0;
        req_vpd   = 1'b0;
        req_page  = 8'h00;
        req_alloc = 16'h0000;
        out_ready = 1'b0;
    end

    task automatic fetch(input logic vpd, input logic [7:0] page, input logic [15:0] alloc,
                         input bit stall);
        int n;
        got.delete();
        rej  = 1'b0;
        hung = 1'b1;
        @(posedge clk);
        req_valid <= 1'b1;
        req_vpd   <= vpd;
        req_page  <= page;
        req_alloc <= alloc;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!req_ready && n < 50);
        if (!req_ready) return;
        // Released lines show the inverse so a stale copy cannot pass
        req_valid <= 1'b0;
        req_vpd   <= ~vpd;
        req_page  <= ~page;
        req_alloc <= ~alloc;
        for (n = 0; n < 400; n++) begin
            @(posedge clk);
            out_ready <= !stall || ($urandom_range(3) != 0);
            if (req_reject) begin
                rej  = 1'b1;
                hung = 1'b0;
                break;
            end
            if (out_valid && out_ready) begin
                got.push_back(out_data);
                if (out_last) begin
                    hung = 1'b0;
                    break;
                end
            end
        end
    endtask
endmodule // vpf_host_model
